// ### gac_pkg.sv
// package: register map and field layout of the gain amplifier control block
`default_nettype none
package gac_pkg;
  // -------------------------------------------------------------------------
  // register map
  // -------------------------------------------------------------------------
  localparam logic [31:0] GAC_BASE_ADDR      = 32'h400F_0000;
  localparam logic [11:0] GAC_AMP_CONTROL    = 12'h000;
  localparam logic [11:0] GAC_AMP_SETTLE_CNT = 12'h004;
  localparam logic [31:0] GAC_CTRL_RESET     = 32'h0000_0000;
  // -------------------------------------------------------------------------
  // field layout
  // -------------------------------------------------------------------------
  localparam int          GAC_EN_BIT         = 0;
  localparam int          GAC_GAIN_LSB       = 4;
  localparam int          GAC_GAIN_W         = 3;
  localparam logic [2:0]  GAC_GAIN_BYPASS    = 3'h7;
  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int          GAC_CLK_HZ         = 10_000_000;
  localparam int          GAC_SETTLE_US      = 20;
  localparam int          GAC_SETTLE_CYC     = (GAC_SETTLE_US * GAC_CLK_HZ + 999_999) / 1_000_000;
  // -------------------------------------------------------------------------
  // gain selector codes
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    GAC_G2  = 3'b000,
    GAC_G3  = 3'b001,
    GAC_G5  = 3'b010,
    GAC_G7  = 3'b011,
    GAC_G9  = 3'b100,
    GAC_G11 = 3'b101,
    GAC_G13 = 3'b110,
    GAC_G1  = 3'b111
  } gac_gain_t;
endpackage
`default_nettype wire

// ### gac_settle.sv
// module: settle timer counting cycles after each time the amplifier is enabled
`default_nettype none
module gac_settle
  import gac_pkg::*;
#(
  parameter int CYCLES = GAC_SETTLE_CYC
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // control
  input  wire logic        enable_i,
  // status
  output logic             settled_o,
  output logic [15:0]      count_o
);
  logic [15:0] count_q;
  logic        settled_q;

  // -------------------------------------------------------------------------
  // counter, restarted whenever the amplifier is off
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !enable_i) begin
      count_q   <= 16'h0000;
      settled_q <= 1'b0;
    end else if (!settled_q) begin
      if (count_q == 16'(CYCLES - 1)) begin
        settled_q <= 1'b1;
      end
      count_q <= count_q + 16'h0001;
    end
  end

  assign settled_o = settled_q;
  assign count_o   = count_q;
endmodule
`default_nettype wire

// ### gac_top.sv
// module: register bank controlling the programmable gain amplifier
//
// Implementation choice: the plain strobed port.
`default_nettype none
module gac_top
  import gac_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [11:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  // amplifier enable
  output logic             amp_enable_o,
  // gain selection
  output logic      [6:0]  amp_gain_sel_o,
  output logic             amp_bypass_o,
  // settling status
  output logic             amp_settled_o,
  // consumers of amplifier output
  output logic             adc_src_amp_o,
  output logic             cmp_src_amp_o
);
  // -------------------------------------------------------------------------
  // internal signals
  // -------------------------------------------------------------------------
  logic        wr_ctl;
  logic        rd_ctl;
  logic        rd_sts;
  logic        amp_enable_d;
  logic        amp_enable_q;
  logic [2:0]  gain_d;
  logic [2:0]  gain_q;
  logic [6:0]  gain_hit;
  logic [6:0]  gain_sel_q;
  logic        bypass_d;
  logic        bypass_q;
  logic        settled;
  logic [15:0] settle_cnt;
  logic        settled_d;
  logic        settled_q;
  logic        adc_src_q;
  logic        cmp_src_q;
  logic [31:0] ctl_view;
  logic [31:0] sts_view;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // -------------------------------------------------------------------------
  // write decode, status register ignores writes
  // -------------------------------------------------------------------------
  always_comb begin
    wr_ctl = 1'b0;
    if (addr_i == GAC_AMP_CONTROL) begin
      wr_ctl = wr_i;
    end
  end

  // -------------------------------------------------------------------------
  // read decode
  // -------------------------------------------------------------------------
  always_comb begin
    rd_ctl = 1'b0;
    rd_sts = 1'b0;
    if (addr_i == GAC_AMP_CONTROL) begin
      rd_ctl = rd_i;
    end else if (addr_i == GAC_AMP_SETTLE_CNT) begin
      rd_sts = rd_i;
    end
  end

  // -------------------------------------------------------------------------
  // enable bit of the control register
  // -------------------------------------------------------------------------
  always_comb begin
    amp_enable_d = amp_enable_q;
    if (wr_ctl) begin
      amp_enable_d = wdata_i[GAC_EN_BIT];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      amp_enable_q <= GAC_CTRL_RESET[GAC_EN_BIT];
    end else begin
      amp_enable_q <= amp_enable_d;
    end
  end

  // -------------------------------------------------------------------------
  // gain field of the control register, reserved bits dropped
  // -------------------------------------------------------------------------
  always_comb begin
    gain_d = gain_q;
    if (wr_ctl) begin
      gain_d = wdata_i[GAC_GAIN_LSB +: GAC_GAIN_W];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gain_q <= GAC_CTRL_RESET[GAC_GAIN_LSB +: GAC_GAIN_W];
    end else begin
      gain_q <= gain_d;
    end
  end

  // -------------------------------------------------------------------------
  // gain decode: one-hot select of the feedback network
  // -------------------------------------------------------------------------
  for (genvar i = 0; i < 7; i++) begin : g_gain_hit
    assign gain_hit[i] = (gain_q == 3'(i));
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      gain_sel_q <= 7'h00;
    end else begin
      gain_sel_q <= gain_hit;
    end
  end

  // -------------------------------------------------------------------------
  // unity bypass path
  // -------------------------------------------------------------------------
  assign bypass_d = (gain_q == GAC_GAIN_BYPASS);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bypass_q <= 1'b0;
    end else begin
      bypass_q <= bypass_d;
    end
  end

  // -------------------------------------------------------------------------
  // settle timer
  // -------------------------------------------------------------------------
  gac_settle i_gac_settle (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .enable_i  (amp_enable_q),
    .settled_o (settled),
    .count_o   (settle_cnt)
  );

  // -------------------------------------------------------------------------
  // settled flag, cleared one cycle after the amplifier is turned off
  // -------------------------------------------------------------------------
  assign settled_d = settled & amp_enable_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      settled_q <= 1'b0;
    end else begin
      settled_q <= settled_d;
    end
  end

  // -------------------------------------------------------------------------
  // source selection for converter and comparator
  // -------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      adc_src_q <= 1'b0;
    end else begin
      adc_src_q <= amp_enable_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cmp_src_q <= 1'b0;
    end else begin
      cmp_src_q <= amp_enable_d;
    end
  end

  // -------------------------------------------------------------------------
  // register views
  // -------------------------------------------------------------------------
  assign ctl_view = {25'h000_0000, gain_q, 3'h0, amp_enable_q};
  assign sts_view = {15'h0000, settled, settle_cnt};

  // -------------------------------------------------------------------------
  // read data, one cycle after the strobe
  // -------------------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_ctl) begin
      rdata_d = ctl_view;
    end else if (rd_sts) begin
      rdata_d = sts_view;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign rdata_o        = rdata_q;
  assign amp_enable_o   = amp_enable_q;
  assign amp_gain_sel_o = gain_sel_q;
  assign amp_bypass_o   = bypass_q;
  assign amp_settled_o  = settled_q;
  assign adc_src_amp_o  = adc_src_q;
  assign cmp_src_amp_o  = cmp_src_q;
endmodule
`default_nettype wire

// ### gac_properties.sv
// checker: port timing of the amplifier control block
`default_nettype none
module gac_properties (
  input wire logic        ref_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        amp_enable_o,
  input wire logic [6:0]  amp_gain_sel_o,
  input wire logic        amp_bypass_o,
  input wire logic        amp_settled_o,
  input wire logic        adc_src_amp_o,
  input wire logic        cmp_src_amp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic ctl_wr = wr_i && addr_i == 12'h000;
  a_enable_set: assert property (ctl_wr && wdata_i[0] |=> amp_enable_o)
    else $error("enable not set");
  a_enable_clr: assert property (ctl_wr && !wdata_i[0] |=> !amp_enable_o)
    else $error("enable not cleared");
  a_gain_decode: assert property (ctl_wr && wdata_i[6:4] != 3'h7 ##1 !wr_i |-> ##1
    amp_gain_sel_o == 7'h01 << $past(wdata_i[6:4], 2)) else $error("gain decode wrong");
  a_bypass_code: assert property (ctl_wr ##1 !wr_i |-> ##1
    amp_bypass_o == ($past(wdata_i[6:4], 2) == 3'h7)) else $error("bypass wrong");
  a_rsvd_zero: assert property (rd_i && addr_i == 12'h000 |=>
    rdata_o[31:7] == 25'h0 && rdata_o[3:1] == 3'h0) else $error("reserved bits set");
  a_read_back: assert property (rd_i && addr_i == 12'h000 |=>
    rdata_o[0] == $past(amp_enable_o)) else $error("readback enable wrong");
  a_src_follow: assert property (adc_src_amp_o == amp_enable_o
    && cmp_src_amp_o == amp_enable_o) else $error("source select wrong");
  a_settle_wait: assert property ($rose(amp_enable_o) |-> !amp_settled_o [*8])
    else $error("settled too early");
  a_settle_drop: assert property (!amp_enable_o |=> !amp_settled_o)
    else $error("settled while off");
  a_unmapped_wr: assert property (wr_i && addr_i != 12'h000 |=> $stable(amp_enable_o))
    else $error("unmapped write took effect");
endmodule
bind gac_top gac_properties i_gac_properties (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .amp_enable_o(amp_enable_o), .amp_gain_sel_o(amp_gain_sel_o), .amp_bypass_o(amp_bypass_o),
  .amp_settled_o(amp_settled_o), .adc_src_amp_o(adc_src_amp_o), .cmp_src_amp_o(cmp_src_amp_o));
`default_nettype wire

// ### gac_top_tb.sv
// testbench: register access and control outputs of the amplifier block
`default_nettype none
module gac_top_tb;
  import gac_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [11:0] addr_i = 12'h000;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic [6:0]  amp_gain_sel_o;
  logic        amp_enable_o, amp_bypass_o, amp_settled_o, adc_src_amp_o, cmp_src_amp_o;
  int          n_errors = 0;
  int          compares = 0;
  int          k;
  gac_top i_gac_top (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .amp_enable_o(amp_enable_o), .amp_gain_sel_o(amp_gain_sel_o), .amp_bypass_o(amp_bypass_o),
    .amp_settled_o(amp_settled_o), .adc_src_amp_o(adc_src_amp_o), .cmp_src_amp_o(cmp_src_amp_o));
  always #50 ref_clk_i = ~ref_clk_i;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", rdata_o, e);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(12'h000, 32'h0000_0000);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      wr(12'h000, 32'hFFFF_FF8F | 32'(k << 4));
      @(posedge ref_clk_i);
      #1;
      if (k < 7) chk("gain_sel", 32'(amp_gain_sel_o), 32'(7'h01 << k));
      chk("bypass", 32'(amp_bypass_o), 32'(k == 7));
      chk("enable", 32'(amp_enable_o), 32'h0000_0001);
      chk("sources", {30'h0, adc_src_amp_o, cmp_src_amp_o}, 32'h0000_0003);
      rd(12'h000, 32'(k << 4) | 32'h0000_0001);
    end
    $display("gain test done");
    wr(12'h000, 32'h0000_0000);
    #1;
    chk("enable_off", {30'h0, amp_enable_o, adc_src_amp_o}, 32'h0000_0000);
    wr(12'h000, 32'h0000_0001);
    for (k = 0; k < 300 && amp_settled_o !== 1'b1; k++) @(negedge ref_clk_i);
    chk("settle_ok", 32'(k >= GAC_SETTLE_CYC - 2 && k <= GAC_SETTLE_CYC + 2), 32'h1);
    if (k >= 300) tally_and_finish();
    $display("settle test done");
    wr(12'h008, 32'hFFFF_FFFF);
    wr(12'h004, 32'h0000_0000);
    rd(12'h004, 32'h0001_0000 | 32'(GAC_SETTLE_CYC));
    rd(12'h008, 32'h0000_0000);
    rd(12'h000, 32'h0000_0001);
    $display("unmapped test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
